// File: core/process_image_exchange.sv
// Purpose: shared process image between a fieldbus master and the instrument
// Assumes: rd_data and src_w* answer one cycle after rd_addr / src_* change
// Notes:   master reaches the images over classic Wishbone, one-cycle ack
//
// Operation
// - output image is fixed sixteen byte block
// - decode 0, 250, 251, 252 commands
// - command counts only when byte changes
// - byte1 is write count, bytes2-3 start
// - base input block always mapped, 32 bytes
// - error word zero means no error
// - acknowledge equals command, or 240 failure
// - command error zero on success
// - echo read window start in bytes 6-7
// - keep twelve window registers refreshed continuously
// - twelve sixteen byte blocks from byte 32
// - unused blocks may hold undefined data
// - each block has one selectable content type
// - weight block takes selected scale data
// - float weight: error, status, value words
// - integer weight: error, status, int, decimal
// - float level block: two level words
// - multi-byte fields most significant byte first
// - restart after hardware configuration change
// - register words are two bytes wide
`timescale 1ns/100ps

module process_image_exchange (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	// wishbone slave
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [11:0]              wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	// instrument state
	input  wire logic [15:0]              inst_error,
	input  wire logic [15:0]              inst_status,
	input  wire logic                     hw_cfg_changed,
	output logic                          restart_req,
	// register read window port
	output logic      [15:0]              rd_addr,
	input  wire logic [15:0]              rd_data,
	// register write port
	output logic                          wr_strobe,
	output logic      [15:0]              wr_addr,
	output logic      [15:0]              wr_data,
	// other commands handed to the instrument
	output logic                          ext_cmd_stb,
	output logic      [7:0]               ext_cmd,
	input  wire logic                     ext_done,
	input  wire logic                     ext_fail,
	input  wire logic [7:0]               ext_err,
	// data block source
	output logic      [3:0]               src_type,
	output logic      [3:0]               src_scale,
	input  wire logic [31:0]              src_w0,
	input  wire logic [31:0]              src_w1,
	input  wire logic [31:0]              src_w2,
	input  wire logic [31:0]              src_w3,
	input  wire logic [15:0]              src_dec
);
	import pix_pkg::*;

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [31:0]              out_w [OUT_WORDS];
	logic [31:0]              cfg_w [NUM_BLK];
	logic [15:0]              win   [WIN_REGS];
	logic [BLK_BITS-1:0]      blk   [NUM_BLK];
	logic [7:0]               last_cmd;
	logic [7:0]               cmd_ack;
	logic [7:0]               cmd_err;
	logic [15:0]              rd_start;
	logic                     prog_reset;
	cmd_state_t               state;
	logic [2:0]               wr_idx;
	logic [2:0]               wr_last;
	logic [15:0]              wr_base;
	logic [3:0]               scan_idx;
	logic [3:0]               scan_d;
	logic [3:0]               scan_dd;
	logic [3:0]               blk_idx;
	logic [3:0]               blk_d;
	logic [3:0]               blk_dd;
	logic                     hw_cfg_seen;

	// restart acts as a local reset so all but the restart detector (restart_req, hw_cfg_seen) come up clean
	wire                      rst = sys_rst | restart_req;

	// ----------------------------------------------------------------
	// wishbone decode
	// ----------------------------------------------------------------
	wire        acc     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire [9:0]  widx    = wb_adr_i[11:2];
	wire [9:0]  in_off  = widx - IN_BASE_W;
	wire [9:0]  cfg_off = widx - CFG_BASE_W;
	wire [9:0]  out_off = widx - OUT_BASE_W;
	wire        hit_out = widx >= OUT_BASE_W && out_off < 10'(OUT_WORDS);
	wire        hit_in  = widx >= IN_BASE_W && in_off < 10'(IN_WORDS);
	wire        hit_cfg = widx >= CFG_BASE_W && cfg_off < 10'(NUM_BLK);
	wire [1:0]  out_k   = out_off[1:0];
	wire [5:0]  in_k    = in_off[5:0];
	wire [3:0]  cfg_k   = cfg_off[3:0];
	wire        wr_out  = acc & wb_we_i & hit_out;
	wire        wr_cfg  = acc & wb_we_i & hit_cfg;

	// ----------------------------------------------------------------
	// image views
	// ----------------------------------------------------------------
	// flat views put byte 0 at the top so words read MSB first
	logic [OUT_BITS-1:0] out_flat;
	wire  [IN_BITS-1:0]  in_flat;
	wire  [7:0]  cmd_byte    = out_flat[OUT_BITS-1 -: 8];
	wire  [7:0]  cnt_byte    = out_flat[OUT_BITS-9 -: 8];
	wire  [15:0] start_field = out_flat[OUT_BITS-17 -: REG_BITS];
	wire  [15:0] status_word = inst_status | (16'(prog_reset) << PRST_BIT);
	wire  [15:0] wr_word     =
		out_flat[OUT_BITS-HDR_BITS/2-1-REG_BITS*int'(wr_idx) -: REG_BITS];

	assign out_flat = {out_w[0], out_w[1], out_w[2], out_w[3]};
	// header of the base input block, error word passes straight through
	assign in_flat[IN_BITS-1 -: HDR_BITS] =
		{inst_error, status_word, cmd_ack, cmd_err, rd_start};

	genvar g;
	generate
		for (g = 0; g < WIN_REGS; g++) begin : g_win
			// two-byte read registers after the header
			assign in_flat[IN_BITS-HDR_BITS-1-REG_BITS*g -: REG_BITS] = win[g];
		end
		for (g = 0; g < NUM_BLK; g++) begin : g_blk
			// blocks sit back to back after the base block
			assign in_flat[IN_BITS-BASE_BYTES*8-1-BLK_BITS*g -: BLK_BITS] = blk[g];
		end
	endgenerate

	// read data selection, unmapped words read zero
	wire [31:0] next_dat =
		hit_in  ? in_flat[IN_BITS-1-WORD_BITS*int'(in_k) -: WORD_BITS] :
		hit_out ? out_w[out_k] :
		hit_cfg ? cfg_w[cfg_k] : 32'h0000_0000;

	// ----------------------------------------------------------------
	// block packing
	// ----------------------------------------------------------------
	// layout by content type and format; other types use four plain words
	function automatic logic [BLK_BITS-1:0] pack_blk(input logic [31:0] cfg);
		logic [3:0] bt;
		logic       is_int;
		bt     = cfg[CFG_TYPE_LSB +: 4];
		is_int = cfg[CFG_FMT_BIT];
		if (!cfg[CFG_USE_BIT]) begin
			pack_blk = '0;
		end else if (bt <= BT_SIGNAL && !is_int) begin
			pack_blk = {src_w0, src_w1, src_w2, 32'h0000_0000};
		end else if (bt <= BT_SIGNAL) begin
			pack_blk = {src_w0[15:0], src_w1[15:0], src_w2, src_dec,
				48'h0000_0000_0000};
		end else if (bt == BT_LEVEL || bt == BT_SETP) begin
			pack_blk = {src_w0, src_w1, 64'h0};
		end else if (bt == BT_LS_INT) begin
			pack_blk = {src_w0[15:0], src_w1[15:0], src_w2[15:0], src_w3[15:0],
				64'h0};
		end else begin
			pack_blk = {src_w0, src_w1, src_w2, src_w3};
		end
	endfunction

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	// a command is only seen when the byte differs from the last byte seen in idle, zero included
	wire is_new    = (state == ST_IDLE) && (cmd_byte != last_cmd);
	wire take_cmd  = is_new && cmd_byte != CMD_NONE;
	wire take_win  = take_cmd && cmd_byte == CMD_WINDOW;
	wire take_wr   = take_cmd && cmd_byte == CMD_WRITE;
	wire take_clr  = take_cmd && cmd_byte == CMD_CLR_PRST;
	wire take_ext  = take_cmd && !take_win && !take_wr && !take_clr;
	wire bad_cnt   = cnt_byte == 8'h00 || cnt_byte > 8'(WR_MAX_CNT);
	wire wr_end    = (state == ST_WRITE) && (wr_idx == wr_last);

	// ----------------------------------------------------------------
	// wishbone slave
	// ----------------------------------------------------------------
	// ack one cycle after the request, dropped the cycle after it
	always_ff @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= acc;
			wb_dat_o <= acc ? next_dat : 32'h0000_0000;
		end
	end

	// output image and block configuration, byte lanes honour sel
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < OUT_WORDS; i++) out_w[i] <= 32'h0000_0000;
			for (int i = 0; i < NUM_BLK; i++) cfg_w[i] <= 32'h0000_0000;
		end else begin
			for (int b = 0; b < 4; b++) begin
				if (wr_out && wb_sel_i[b]) out_w[out_k][8*b +: 8] <= wb_dat_i[8*b +: 8];
				if (wr_cfg && wb_sel_i[b]) cfg_w[cfg_k][8*b +: 8] <= wb_dat_i[8*b +: 8];
			end
		end
	end

	// ----------------------------------------------------------------
	// command sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state    <= ST_IDLE;
			last_cmd <= CMD_NONE;
			wr_idx   <= 3'h0;
			wr_last  <= 3'h0;
			wr_base  <= 16'h0000;
		end else begin
			if (is_new) last_cmd <= cmd_byte;
			unique case (state)
				ST_IDLE: begin
					wr_idx  <= 3'h0;
					wr_last <= cnt_byte[2:0] - 3'h1;
					wr_base <= start_field;
					if (take_wr && !bad_cnt) state <= ST_WRITE;
					else if (take_ext) state <= ST_EXT;
				end
				ST_WRITE: begin
					wr_idx <= wr_idx + 3'h1;
					if (wr_end) state <= ST_IDLE;
				end
				ST_EXT: begin
					if (ext_done) state <= ST_IDLE;
				end
			endcase
		end
	end

	// answer bytes: command number on success, F0 plus code on failure
	always_ff @(posedge clk) begin
		if (rst) begin
			cmd_ack <= CMD_NONE;
			cmd_err <= ERR_NONE;
		end else if ((take_wr && bad_cnt)) begin
			cmd_ack <= ACK_FAIL;
			cmd_err <= ERR_BAD_COUNT;
		end else if (take_win || take_clr || wr_end) begin
			cmd_ack <= take_win ? CMD_WINDOW : take_clr ? CMD_CLR_PRST : CMD_WRITE;
			cmd_err <= ERR_NONE;
		end else if (state == ST_EXT && ext_done) begin
			cmd_ack <= ext_fail ? ACK_FAIL : ext_cmd;
			cmd_err <= ext_fail ? ext_err : ERR_NONE;
		end
	end

	// read window start and program reset flag
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_start   <= 16'h0000;
			prog_reset <= 1'b1;
		end else begin
			if (take_win) rd_start <= start_field;
			if (take_clr) prog_reset <= 1'b0;
		end
	end

	// register write port, one word per cycle from the output image
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_strobe <= 1'b0;
			wr_addr   <= 16'h0000;
			wr_data   <= 16'h0000;
		end else begin
			wr_strobe <= state == ST_WRITE;
			wr_addr   <= wr_base + 16'(wr_idx);
			wr_data   <= wr_word;
		end
	end

	// other codes go to the instrument, which answers with ext_done
	always_ff @(posedge clk) begin
		if (rst) begin
			ext_cmd_stb <= 1'b0;
			ext_cmd     <= CMD_NONE;
		end else begin
			ext_cmd_stb <= take_ext;
			if (take_ext) ext_cmd <= cmd_byte;
		end
	end

	// ----------------------------------------------------------------
	// window and block refresh
	// ----------------------------------------------------------------
	// round robin; a window change is fully visible within fourteen cycles
	// the fetch is two edges deep (address register, then the registered
	// answer), so the slot index is delayed twice to land on the right entry
	always_ff @(posedge clk) begin
		if (rst) begin
			scan_idx <= 4'h0;
			scan_d   <= 4'h0;
			scan_dd  <= 4'h0;
			rd_addr  <= 16'h0000;
			for (int i = 0; i < WIN_REGS; i++) win[i] <= 16'h0000;
		end else begin
			scan_idx <= (scan_idx == 4'(WIN_REGS - 1)) ? 4'h0 : scan_idx + 4'h1;
			scan_d   <= scan_idx;
			scan_dd  <= scan_d;
			rd_addr  <= rd_start + 16'(scan_idx);
			win[scan_dd] <= rd_data;
		end
	end

	// same two-deep pipeline as the window: selection out, source data back
	always_ff @(posedge clk) begin
		if (rst) begin
			blk_idx   <= 4'h0;
			blk_d     <= 4'h0;
			blk_dd    <= 4'h0;
			src_type  <= 4'h0;
			src_scale <= 4'h0;
			for (int i = 0; i < NUM_BLK; i++) blk[i] <= '0;
		end else begin
			blk_idx   <= (blk_idx == 4'(NUM_BLK - 1)) ? 4'h0 : blk_idx + 4'h1;
			blk_d     <= blk_idx;
			blk_dd    <= blk_d;
			src_type  <= cfg_w[blk_idx][CFG_TYPE_LSB +: 4];
			src_scale <= cfg_w[blk_idx][CFG_SCALE_LSB +: 4];
			blk[blk_dd] <= pack_blk(cfg_w[blk_dd]);
		end
	end

	// one-cycle restart pulse on a rising request; it also resets this block
	// edge detected so a request held high restarts once, not every other cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			restart_req <= 1'b0;
			hw_cfg_seen <= 1'b0;
		end else begin
			hw_cfg_seen <= hw_cfg_changed;
			restart_req <= hw_cfg_changed & ~hw_cfg_seen;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_ack_single: assert property (@(posedge clk) disable iff (rst)
		wb_ack_o |=> !wb_ack_o) else $error("ack held past one cycle");
	a_window_ack: assert property (@(posedge clk) disable iff (rst)
		take_win |=> cmd_ack == CMD_WINDOW && cmd_err == ERR_NONE)
		else $error("window change not acknowledged");
	a_window_echo: assert property (@(posedge clk) disable iff (rst)
		take_win |=> rd_start == $past(start_field)) else $error("start not echoed");
	a_bad_count: assert property (@(posedge clk) disable iff (rst)
		take_wr && bad_cnt |=> cmd_ack == ACK_FAIL && cmd_err == ERR_BAD_COUNT
		&& state == ST_IDLE) else $error("bad count not rejected");
	a_write_burst: assert property (@(posedge clk) disable iff (rst)
		take_wr && cnt_byte == 8'h02 |=> ##1 wr_strobe ##1 wr_strobe ##1 !wr_strobe
		&& cmd_ack == CMD_WRITE) else $error("write burst length wrong");
	a_clear_flag: assert property (@(posedge clk) disable iff (rst)
		take_clr |=> !prog_reset && cmd_ack == CMD_CLR_PRST)
		else $error("program reset flag not cleared");
	a_same_cmd: assert property (@(posedge clk) disable iff (rst)
		state == ST_IDLE && !is_new |=> $stable(cmd_ack) && state == ST_IDLE)
		else $error("unchanged command acted on");
	a_win_addr: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> rd_addr == $past(rd_start) + 16'($past(scan_idx)))
		else $error("window address wrong");
	a_restart_seq: assert property (@(posedge clk) disable iff (sys_rst)
		hw_cfg_changed && !hw_cfg_seen |=> restart_req ##1 prog_reset
		&& state == ST_IDLE) else $error("restart not performed");
	a_ext_answer: assert property (@(posedge clk) disable iff (rst)
		state == ST_EXT && ext_done && !ext_fail |=> cmd_err == ERR_NONE
		&& cmd_ack == ext_cmd) else $error("external answer wrong");
endmodule

// File: core/pix_pkg.sv
// Purpose: constants shared by the process image exchange block
// Assumes: 32-bit classic Wishbone, byte addressed, word aligned
// Notes:   multi-byte image fields are stored most significant byte first

package pix_pkg;
	// ----------------------------------------------------------------
	// image geometry
	// ----------------------------------------------------------------
	localparam int OUT_BYTES   = 16;
	localparam int BASE_BYTES  = 32;
	localparam int BLK_BYTES   = 16;
	localparam int NUM_BLK     = 12;
	localparam int WIN_REGS    = 12;
	localparam int WR_MAX      = 6;
	localparam int REG_BITS    = 16;
	localparam int WORD_BITS   = 32;
	localparam int HDR_BITS    = 64;
	localparam int BLK_BITS    = BLK_BYTES * 8;
	localparam int OUT_WORDS   = OUT_BYTES / 4;
	localparam int IN_BYTES    = BASE_BYTES + NUM_BLK * BLK_BYTES;
	localparam int IN_WORDS    = IN_BYTES / 4;
	localparam int IN_BITS     = IN_BYTES * 8;
	localparam int OUT_BITS    = OUT_BYTES * 8;

	// ----------------------------------------------------------------
	// command codes and answers
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_NONE      = 8'h00;
	localparam logic [7:0] CMD_WINDOW    = 8'hFA;
	localparam logic [7:0] CMD_WRITE     = 8'hFB;
	localparam logic [7:0] CMD_CLR_PRST  = 8'hFC;
	localparam logic [7:0] ACK_FAIL      = 8'hF0;
	localparam logic [7:0] ERR_NONE      = 8'h00;
	localparam logic [7:0] ERR_BAD_COUNT = 8'h01;
	localparam logic [2:0] WR_MAX_CNT    = 3'h6;
	localparam int         PRST_BIT      = 0;

	// ----------------------------------------------------------------
	// wishbone word indices (byte address / 4)
	// ----------------------------------------------------------------
	localparam logic [9:0] OUT_BASE_W = 10'h000;
	localparam logic [9:0] IN_BASE_W  = 10'h010;
	localparam logic [9:0] CFG_BASE_W = 10'h080;

	// ----------------------------------------------------------------
	// block configuration word fields
	// ----------------------------------------------------------------
	localparam int CFG_SCALE_LSB = 0;
	localparam int CFG_FMT_BIT   = 4;
	localparam int CFG_TYPE_LSB  = 8;
	localparam int CFG_USE_BIT   = 16;

	// block content types
	localparam logic [3:0] BT_GROSS  = 4'h0;
	localparam logic [3:0] BT_NET    = 4'h1;
	localparam logic [3:0] BT_DISP   = 4'h2;
	localparam logic [3:0] BT_FLOW   = 4'h3;
	localparam logic [3:0] BT_SIGNAL = 4'h4;
	localparam logic [3:0] BT_LEVEL  = 4'h5;
	localparam logic [3:0] BT_SETP   = 4'h6;
	localparam logic [3:0] BT_LS_INT = 4'hA;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_WRITE = 3'b010,
		ST_EXT   = 3'b100
	} cmd_state_t;
endpackage

// File: verification/instr_model.sv
// Purpose: instrument side of the block: registers, write port, commands, block data
// Assumes: answers one cycle after the address or the block selection changes
// Notes:   odd external command codes fail, so both answers are seen
`timescale 1ns/100ps

module instr_model (
	// clock
	input  wire logic        clk,
	// register ports
	input  wire logic [15:0] rd_addr,
	output logic      [15:0] rd_data,
	input  wire logic        wr_strobe,
	input  wire logic [15:0] wr_addr,
	input  wire logic [15:0] wr_data,
	// external commands
	input  wire logic        ext_cmd_stb,
	input  wire logic [7:0]  ext_cmd,
	output logic             ext_done,
	output logic             ext_fail,
	output logic      [7:0]  ext_err,
	// block source
	input  wire logic [3:0]  src_type,
	input  wire logic [3:0]  src_scale,
	output logic      [31:0] src_w0,
	output logic      [31:0] src_w1,
	output logic      [31:0] src_w2,
	output logic      [31:0] src_w3,
	output logic      [15:0] src_dec
);
	logic [15:0] mem [0:255];
	logic [1:0]  busy_cnt;

	// every register starts with a value that names its own number
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 16'h5A00 + 16'(i);
		busy_cnt = 2'h0;
		ext_done = 1'b0;
		rd_data = 16'h0000;
	end

	// two-byte registers, answered one cycle after the address
	always @(posedge clk) begin
		rd_data <= mem[rd_addr[7:0]];
		if (wr_strobe)
			mem[wr_addr[7:0]] <= wr_data;
	end

	// slow answer: done four cycles after the strobe, not at once
	always @(posedge clk) begin
		ext_done <= (busy_cnt == 2'h1);
		ext_fail <= ext_cmd[0];
		ext_err  <= ext_cmd[0] ? 8'h22 : 8'h00;
		if (ext_cmd_stb)
			busy_cnt <= 2'h3;
		else if (busy_cnt != 2'h0)
			busy_cnt <= busy_cnt - 2'h1;
	end

	// data of the selected scale, tagged with type and scale
	always @(posedge clk) begin
		src_w0  <= {24'hE00000, src_type, src_scale};
		src_w1  <= {24'h5A0000, src_type, src_scale};
		src_w2  <= {24'hDA0000, src_type, src_scale};
		src_w3  <= {24'h330000, src_type, src_scale};
		src_dec <= {8'h0D, src_type, src_scale};
	end
endmodule

// File: verification/tb_process_image_exchange.sv
// Purpose: self-checking bench for the process image exchange block
// Assumes: one-cycle wishbone answer; command answers polled in the input image
// Notes:   all waits are bounded; a cycle ceiling cuts a hang short
`timescale 1ns/100ps

module tb_process_image_exchange;
	import pix_pkg::*;

	typedef struct {
		logic [7:0]  cmd;
		logic [7:0]  cnt;
		logic [15:0] start;
		logic [95:0] d;
		logic [7:0]  ack;
		logic [7:0]  err;
	} row_t;

	logic clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, hw_cfg_changed, restart_req;
	logic wr_strobe, ext_cmd_stb, ext_done, ext_fail;
	logic [11:0] wb_adr_i;
	logic [3:0]  wb_sel_i, src_type, src_scale;
	logic [31:0] wb_dat_i, wb_dat_o, src_w0, src_w1, src_w2, src_w3, rd;
	logic [15:0] inst_error, inst_status, rd_addr, rd_data, wr_addr, wr_data, src_dec;
	logic [15:0] exp_start, v;
	logic [7:0]  ext_cmd, ext_err;
	int          miscompares, n_checks, cycles, t;
	row_t        rows [8];

	process_image_exchange u_process_image_exchange (.*);
	instr_model u_instr_model (.*);

	// clock and cycle ceiling
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			give_verdict;
		end
	end

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// classic cycle: hold the request until ack is sampled, then one idle cycle
	task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] wd);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		if (n >= 20)
			chk("ack", 32'h1, 32'h0);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask

	// poll the answer bytes until the expected acknowledge shows
	task automatic wait_ack(input logic [7:0] a);
		t = 0;
		do begin
			wb(1'b0, 12'h044, 32'h0);
			t++;
		end while (rd[31:24] !== a && t < 30);
	endtask

	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, hw_cfg_changed} = 4'h0;
		wb_adr_i = 12'h000;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'hF;
		inst_error = 16'h0000;
		inst_status = 16'h1230;
		sys_rst = 1'b1;
		exp_start = 16'h0000;
		rows[0] = '{CMD_WINDOW, 8'h00, 16'h0010, 96'h0, 8'hFA, 8'h00};
		rows[1] = '{CMD_WRITE, 8'h07, 16'h0028, 96'h111122223333444455556666, 8'hF0, 8'h01};
		rows[2] = '{CMD_WRITE, 8'h02, 16'h0020, 96'hA1B2C3D4_00000000_00000000, 8'hFB, 8'h00};
		rows[3] = '{CMD_WRITE, 8'h00, 16'h002C, 96'h0, 8'hF0, 8'h01};
		rows[4] = '{CMD_CLR_PRST, 8'h00, 16'h0000, 96'h0, 8'hFC, 8'h00};
		rows[5] = '{8'h10, 8'h00, 16'h0000, 96'h0, 8'h10, 8'h00};
		rows[6] = '{8'h11, 8'h00, 16'h0000, 96'h0, 8'hF0, 8'h22};
		rows[7] = '{CMD_WRITE, 8'h06, 16'h0030, 96'h0102030405060708090A0B0C, 8'hFB, 8'h00};
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		wb(1'b0, 12'h044, 32'h0);
		chk("answer reset", 32'h0, rd);
		wb(1'b0, 12'h040, 32'h0);
		chk("status reset", 32'h00001231, rd);
		$display("test reset done");
		// command rows: a zero byte first so a repeated code counts as new
		foreach (rows[i]) begin
			wb(1'b1, 12'h000, 32'h0);
			wb(1'b1, 12'h004, rows[i].d[95:64]);
			wb(1'b1, 12'h008, rows[i].d[63:32]);
			wb(1'b1, 12'h00C, rows[i].d[31:0]);
			wb(1'b1, 12'h000, {rows[i].cmd, rows[i].cnt, rows[i].start});
			if (rows[i].cmd == CMD_WINDOW)
				exp_start = rows[i].start;
			wait_ack(rows[i].ack);
			chk("answer", {rows[i].ack, rows[i].err, exp_start}, rd);
			for (int k = 0; k < 6 && rows[i].cmd == CMD_WRITE; k++) begin
				v = 16'h5A00 + rows[i].start + 16'(k);
				if (rows[i].ack == CMD_WRITE && k < rows[i].cnt)
					v = rows[i].d[95 - 16 * k -: 16];
				chk("reg", {16'h0, v}, {16'h0, u_instr_model.mem[8'(rows[i].start + 16'(k))]});
			end
			$display("test row %0d done", i);
		end
		for (int k = 0; k < 6; k++) begin
			wb(1'b0, 12'(12'h048 + 4 * k), 32'h0);
			chk("window", {16'h5A10 + 16'(2 * k), 16'h5A11 + 16'(2 * k)}, rd);
		end
		inst_error <= 16'h8042;
		wb(1'b0, 12'h040, 32'h0);
		chk("status", 32'h80421230, rd);
		wb(1'b1, 12'h040, 32'hFFFFFFFF);
		wb(1'b1, 12'h180, 32'hFFFFFFFF);
		wb(1'b0, 12'h180, 32'h0);
		chk("unmapped", 32'h0, rd);
		wb(1'b0, 12'h040, 32'h0);
		chk("read only", 32'h80421230, rd);
		$display("test status done");
		// same code again without a different byte between: must be ignored
		wb(1'b1, 12'h000, {CMD_WINDOW, 8'h00, 16'h0040});
		wait_ack(CMD_WINDOW);
		wb(1'b1, 12'h000, {CMD_WINDOW, 8'h00, 16'h0000});
		wb(1'b0, 12'h044, 32'h0);
		wb(1'b0, 12'h044, 32'h0);
		chk("repeat", {CMD_WINDOW, ERR_NONE, 16'h0040}, rd);
		$display("test repeat done");
		// block 1 float gross of scale 3, block 12 float level of scale 2,
		// block 2 integer gross of scale 1, block 4 integer level of scale 1
		wb(1'b1, 12'h200, 32'h00010003);
		wb(1'b1, 12'h22C, 32'h00010502);
		wb(1'b1, 12'h204, 32'h00010011);
		wb(1'b1, 12'h20C, 32'h00010A01);
		for (int k = 0; k < 5; k++) begin
			wb(1'b0, 12'h200, 32'h0);
			chk("config", 32'h00010003, rd);
		end
		for (int k = 0; k < 3; k++) begin
			wb(1'b0, 12'(12'h060 + 4 * k), 32'h0);
			chk("weight block", {8'hE0 ^ 8'(k == 1 ? 8'hBA : k == 2 ? 8'h3A : 8'h0), 24'h3}, rd);
		end
		wb(1'b0, 12'h110, 32'h0);
		chk("level block", 32'hE0000052, rd);
		wb(1'b0, 12'h114, 32'h0);
		chk("level block", 32'h5A000052, rd);
		wb(1'b0, 12'h070, 32'h0);
		chk("int block", 32'h00010001, rd);
		wb(1'b0, 12'h074, 32'h0);
		chk("int block", 32'hDA000001, rd);
		wb(1'b0, 12'h078, 32'h0);
		chk("int block", 32'h0D010000, rd);
		wb(1'b0, 12'h080, 32'h0);
		chk("idle block", 32'h0, rd);
		wb(1'b0, 12'h090, 32'h0);
		chk("int level block", 32'h00A100A1, rd);
		$display("test blocks done");
		hw_cfg_changed <= 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (restart_req !== 1'b1 && t < 10);
		chk("restart", 32'h1, {31'h0, restart_req});
		@(posedge clk);
		chk("restart once", 32'h0, {31'h0, restart_req});
		hw_cfg_changed <= 1'b0;
		repeat (2) @(posedge clk);
		wb(1'b0, 12'h200, 32'h0);
		chk("config after restart", 32'h0, rd);
		wb(1'b0, 12'h040, 32'h0);
		chk("status after restart", 32'h80421231, rd);
		$display("test restart done");
		give_verdict;
	end
endmodule
